/* pccr_host_model.sv */
// host side model that sends slot power limit messages toward the register bank
`timescale 1ns/10ps
module pccr_host_model (
    input wire logic mclk,
    output logic spl_valid,
    output logic [9:0] spl_payload
);
    initial begin
        spl_valid = 1'b0;
        spl_payload = 10'h2aa;
    end
    // called just after a falling edge; the strobe stands for exactly one rising edge
    task automatic send_limit(input logic [1:0] scale, input logic [7:0] value);
        spl_valid = 1'b1;
        spl_payload = {scale, value};
        @(negedge mclk);
        spl_valid = 1'b0;
        // payload means nothing without the strobe, so scramble it
        spl_payload = ~spl_payload;
    endtask
endmodule // pccr_host_model

/* pccr_id_store.sv */
// one 16-bit board identification word, cleared only by the fundamental reset
`timescale 1ns/10ps
module pccr_id_store
    import pccr_pkg::*;
(
    input wire logic mclk,
    input wire logic fundamental_chip_reset_b,
    input wire logic eeprom_load,
    input wire logic [15:0] eeprom_word,
    input wire logic alias_wr,
    input wire logic [15:0] alias_word,
    output logic [15:0] code_q
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // no warm reset input on purpose: only the fundamental reset clears
    always_ff @(posedge mclk or negedge fundamental_chip_reset_b) begin
        if (!fundamental_chip_reset_b) begin
            code_q <= BOARD_CODE_CLEAR;
        end else if (alias_wr) begin
            code_q <= alias_word;
        end else if (eeprom_load) begin
            code_q <= eeprom_word;
        end
    end

endmodule // pccr_id_store

/* pccr_pkg.sv */
// package of offsets, field layouts and reset values for the capability registers
package pccr_pkg;

    // ------------------------------------------------------------------
    // configuration offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_SUBSYS_CAP_HEADER = 8'h80;
    localparam logic [7:0] OFS_SUBSYS_CAP_LINK = 8'h81;
    localparam logic [7:0] OFS_BOARD_VENDOR = 8'h84;
    localparam logic [7:0] OFS_BOARD_PRODUCT = 8'h86;
    localparam logic [7:0] OFS_EXPRESS_CAP_HEADER = 8'h90;
    localparam logic [7:0] OFS_EXPRESS_CAP_LINK = 8'h91;
    localparam logic [7:0] OFS_EXPRESS_CAP_SUMMARY = 8'h92;
    localparam logic [7:0] OFS_DEVICE_FEATURE = 8'h94;

    // ------------------------------------------------------------------
    // fixed values
    // ------------------------------------------------------------------
    localparam logic [7:0] SUBSYS_CAP_HEADER_VAL = 8'h0d;
    localparam logic [7:0] SUBSYS_CAP_LINK_VAL = 8'h90;
    localparam logic [7:0] EXPRESS_CAP_HEADER_VAL = 8'h10;
    localparam logic [7:0] EXPRESS_CAP_LINK_VAL = 8'h00;
    localparam logic [15:0] BOARD_CODE_CLEAR = 16'h0000;

    // capabilities summary word fields
    localparam logic [3:0] CAP_VERSION_VAL = 4'h1;
    localparam logic [3:0] PORT_KIND_FIELD_VAL = 4'h7;
    localparam logic SLOT_IMPL_VAL = 1'b0;
    localparam int SUM_VERSION_LSB = 0;
    localparam int SUM_PORT_KIND_LSB = 4;
    localparam int SUM_SLOT_BIT = 8;
    localparam logic [15:0] EXPRESS_CAP_SUMMARY_RST = 16'h0071;

    // device feature word fields
    localparam logic [31:0] DEVICE_FEATURE_RST = 32'h0000_8002;
    localparam logic [2:0] MAX_PAYLOAD_SUPPORTED_VAL = 3'h2;
    localparam logic ROLE_ERROR_REPORTING_VAL = 1'b1;
    localparam int FEAT_MPS_LSB = 0;
    localparam int FEAT_ROLE_ERR_BIT = 15;
    localparam int FEAT_VALUE_LSB = 18;
    localparam int FEAT_SCALE_LSB = 26;

    // slot power limit message payload layout
    localparam int SPL_VALUE_LSB = 0;
    localparam int SPL_SCALE_LSB = 8;
    localparam logic [1:0] POWER_SCALE_RST = 2'h0;
    localparam logic [7:0] POWER_VALUE_RST = 8'h00;

    // scale encodings and their milliwatt factors
    typedef enum logic [1:0] {
        PCCR_SCALE_1_0 = 2'b00,
        PCCR_SCALE_0_1 = 2'b01,
        PCCR_SCALE_0_01 = 2'b10,
        PCCR_SCALE_0_001 = 2'b11
    } pccr_scale_t;
    localparam logic [9:0] MW_FACTOR_1_0 = 10'h3e8;
    localparam logic [9:0] MW_FACTOR_0_1 = 10'h064;
    localparam logic [9:0] MW_FACTOR_0_01 = 10'h00a;
    localparam logic [9:0] MW_FACTOR_0_001 = 10'h001;

endpackage : pccr_pkg

/* pccr_power_capture.sv */
// captures the slot power limit message payload and works out the limit in mW
`timescale 1ns/10ps
module pccr_power_capture
    import pccr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic warm_clear,
    input wire logic spl_valid,
    input wire logic [9:0] spl_payload,
    output logic [1:0] captured_power_scale_q,
    output logic [7:0] captured_power_value_q,
    output logic [17:0] slot_power_mw_q
);

    logic [9:0] factor;

    // ------------------------------------------------------------------
    // capture
    // ------------------------------------------------------------------
    // a message in the warm-clear cycle wins, so it is never lost
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            captured_power_scale_q <= POWER_SCALE_RST;
            captured_power_value_q <= POWER_VALUE_RST;
        end else if (spl_valid) begin
            captured_power_scale_q <= spl_payload[SPL_SCALE_LSB +: 2];
            captured_power_value_q <= spl_payload[SPL_VALUE_LSB +: 8];
        end else if (warm_clear) begin
            captured_power_scale_q <= POWER_SCALE_RST;
            captured_power_value_q <= POWER_VALUE_RST;
        end
    end

    // ------------------------------------------------------------------
    // limit in milliwatts, one cycle behind the captured fields
    // ------------------------------------------------------------------
    always_comb begin
        unique case (pccr_scale_t'(captured_power_scale_q))
            PCCR_SCALE_1_0: factor = MW_FACTOR_1_0;
            PCCR_SCALE_0_1: factor = MW_FACTOR_0_1;
            PCCR_SCALE_0_01: factor = MW_FACTOR_0_01;
            PCCR_SCALE_0_001: factor = MW_FACTOR_0_001;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            slot_power_mw_q <= 18'h00000;
        end else begin
            slot_power_mw_q <= 18'(captured_power_value_q) * 18'(factor);
        end
    end

endmodule // pccr_power_capture

/* pccr_regs.sv */
// capability list registers: board identification item and express capability item
//
// Overview of operation
// - byte 80h always reads 0Dh, the board identification item header.
// - byte 81h reads 90h, linking on to the express capability item.
// - vendor word 84h and product word 86h are read-only; loaded by eeprom or alias.
// - both identification words clear on fundamental reset only, never on warm reset.
// - byte 90h always reads 10h, the express capability item header.
// - byte 91h reads 00h, ending the capability list.
// - summary word bits 7:4 read 0111b, a bridge to the older parallel bus.
// - summary word bits 3:0 read capability version 1h.
// - summary word bit 8, slot implemented, always reads zero.
// - summary word bits 15:9 always read zero.
// - feature word at 94h is read-only, powering up as 0000 8002.
// - slot power message payload bits 9:8 land in feature bits 27:26.
// - captured scale 00/01/10/11 means multiplier 1.0/0.1/0.01/0.001.
// - payload bits 7:0 land in feature bits 25:18; limit is value times scale.
// - feature word bits 31:28 always read zero.
// - feature word bits 17:16 always read zero.
// - feature bits 2:0 read 010b, a 512 byte largest payload.
// - feature bit 15 reads one, role based error reporting supported.
`timescale 1ns/10ps
module pccr_regs
    import pccr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic warm_reset,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    output logic cfg_ack_q,
    output logic cfg_hit_q,
    output logic [31:0] cfg_rdata_q,
    output logic cfg_wr_ignored_q,
    input wire logic eeprom_load,
    input wire logic [31:0] eeprom_word,
    input wire logic alias_wr,
    input wire logic [31:0] alias_word,
    input wire logic spl_valid,
    input wire logic [9:0] spl_payload,
    output logic [15:0] board_vendor_code_q,
    output logic [15:0] board_product_code_q,
    output logic [1:0] captured_power_scale_q,
    output logic [7:0] captured_power_value_q,
    output logic [17:0] slot_power_mw_q
);

    // ------------------------------------------------------------------
    // dword addresses of the four occupied words
    // ------------------------------------------------------------------
    localparam logic [5:0] DW_SUBSYS = OFS_SUBSYS_CAP_HEADER[7:2];
    localparam logic [5:0] DW_BOARD = OFS_BOARD_VENDOR[7:2];
    localparam logic [5:0] DW_EXPRESS = OFS_EXPRESS_CAP_HEADER[7:2];
    localparam logic [5:0] DW_FEATURE = OFS_DEVICE_FEATURE[7:2];

    // byte lanes of each field inside its dword
    localparam int LANE_VENDOR = int'(OFS_BOARD_VENDOR[1:0]) * 8;
    localparam int LANE_PRODUCT = int'(OFS_BOARD_PRODUCT[1:0]) * 8;
    localparam int LANE_SUB_HDR = int'(OFS_SUBSYS_CAP_HEADER[1:0]) * 8;
    localparam int LANE_SUB_LINK = int'(OFS_SUBSYS_CAP_LINK[1:0]) * 8;
    localparam int LANE_EXP_HDR = int'(OFS_EXPRESS_CAP_HEADER[1:0]) * 8;
    localparam int LANE_EXP_LINK = int'(OFS_EXPRESS_CAP_LINK[1:0]) * 8;
    localparam int LANE_SUMMARY = int'(OFS_EXPRESS_CAP_SUMMARY[1:0]) * 8;

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [5:0] dword_sel;
    logic hit_d;
    logic [15:0] summary_word;
    logic [31:0] feature_word;
    logic [31:0] subsys_dword;
    logic [31:0] board_dword;
    logic [31:0] express_dword;
    logic [31:0] read_word;
    logic [31:0] lane_mask;
    logic [31:0] cfg_rdata_d;
    logic wr_drop_d;

    // write data carries nothing these registers keep
    logic [31:0] wdata_unused;
    assign wdata_unused = cfg_wdata;

    // ------------------------------------------------------------------
    // identification words
    // ------------------------------------------------------------------
    // the block's own rst_b is the fundamental reset; warm_reset never
    // reaches these two, so a hot reset keeps the board identity
    pccr_id_store u_vendor (
        .mclk(mclk),
        .fundamental_chip_reset_b(rst_b),
        .eeprom_load(eeprom_load),
        .eeprom_word(eeprom_word[15:0]),
        .alias_wr(alias_wr),
        .alias_word(alias_word[15:0]),
        .code_q(board_vendor_code_q)
    );

    pccr_id_store u_product (
        .mclk(mclk),
        .fundamental_chip_reset_b(rst_b),
        .eeprom_load(eeprom_load),
        .eeprom_word(eeprom_word[31:16]),
        .alias_wr(alias_wr),
        .alias_word(alias_word[31:16]),
        .code_q(board_product_code_q)
    );

    // ------------------------------------------------------------------
    // slot power limit capture
    // ------------------------------------------------------------------
    pccr_power_capture u_power (
        .mclk(mclk),
        .rst_b(rst_b),
        .warm_clear(warm_reset),
        .spl_valid(spl_valid),
        .spl_payload(spl_payload),
        .captured_power_scale_q(captured_power_scale_q),
        .captured_power_value_q(captured_power_value_q),
        .slot_power_mw_q(slot_power_mw_q)
    );

    // ------------------------------------------------------------------
    // capabilities summary word
    // ------------------------------------------------------------------
    always_comb begin
        summary_word = 16'h0000;
        summary_word[SUM_VERSION_LSB +: 4] = CAP_VERSION_VAL;
        summary_word[SUM_PORT_KIND_LSB +: 4] = PORT_KIND_FIELD_VAL;
        summary_word[SUM_SLOT_BIT] = SLOT_IMPL_VAL;
    end

    // ------------------------------------------------------------------
    // device feature word
    // ------------------------------------------------------------------
    // bits 31:28 and 17:16 stay at the cleared value; the latency and
    // indicator fields are not held here and read as their zero default
    always_comb begin
        feature_word = 32'h0000_0000;
        feature_word[FEAT_MPS_LSB +: 3] = MAX_PAYLOAD_SUPPORTED_VAL;
        feature_word[FEAT_ROLE_ERR_BIT] = ROLE_ERROR_REPORTING_VAL;
        feature_word[FEAT_VALUE_LSB +: 8] = captured_power_value_q;
        feature_word[FEAT_SCALE_LSB +: 2] = captured_power_scale_q;
    end

    // ------------------------------------------------------------------
    // dword images
    // ------------------------------------------------------------------
    always_comb begin
        subsys_dword = 32'h0000_0000;
        subsys_dword[LANE_SUB_HDR +: 8] = SUBSYS_CAP_HEADER_VAL;
        subsys_dword[LANE_SUB_LINK +: 8] = SUBSYS_CAP_LINK_VAL;
    end

    always_comb begin
        board_dword = 32'h0000_0000;
        board_dword[LANE_VENDOR +: 16] = board_vendor_code_q;
        board_dword[LANE_PRODUCT +: 16] = board_product_code_q;
    end

    always_comb begin
        express_dword = 32'h0000_0000;
        express_dword[LANE_EXP_HDR +: 8] = EXPRESS_CAP_HEADER_VAL;
        express_dword[LANE_EXP_LINK +: 8] = EXPRESS_CAP_LINK_VAL;
        express_dword[LANE_SUMMARY +: 16] = summary_word;
    end

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    // the low two address bits are ignored: requests are whole dwords
    // and byte enables pick the lanes
    assign dword_sel = cfg_addr[7:2];

    always_comb begin
        hit_d = 1'b1;
        read_word = 32'h0000_0000;
        unique case (dword_sel)
            DW_SUBSYS: read_word = subsys_dword;
            DW_BOARD: read_word = board_dword;
            DW_EXPRESS: read_word = express_dword;
            DW_FEATURE: read_word = feature_word;
            default: hit_d = 1'b0;
        endcase
    end

    // lanes not enabled read zero so a narrow read sees only its bytes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            lane_mask[i*8 +: 8] = {8{cfg_be[i]}};
        end
    end

    // reads return the masked image; writes return zero data
    always_comb begin
        cfg_rdata_d = 32'h0000_0000;
        if (!cfg_wr) begin
            cfg_rdata_d = read_word & lane_mask;
        end
    end

    // a write into the occupied words is swallowed: no storage sees it
    assign wr_drop_d = cfg_req && cfg_wr && hit_d;

    // ------------------------------------------------------------------
    // answer: every request, read or write, is answered the next cycle
    // ------------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_ack_q <= 1'b0;
        end else begin
            cfg_ack_q <= cfg_req;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_hit_q <= 1'b0;
        end else if (cfg_req) begin
            cfg_hit_q <= hit_d;
        end else begin
            cfg_hit_q <= 1'b0;
        end
    end

    // data holds between answers so a slow consumer can still pick it up
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata_q <= 32'h0000_0000;
        end else if (cfg_req) begin
            cfg_rdata_q <= cfg_rdata_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            cfg_wr_ignored_q <= 1'b0;
        end else begin
            cfg_wr_ignored_q <= wr_drop_d;
        end
    end

endmodule // pccr_regs

/* pccr_regs_sva.sv */
// concurrent checks on the ports of the capability register bank
`timescale 1ns/10ps
module pccr_regs_sva
    import pccr_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic cfg_req,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic cfg_ack_q,
    input wire logic [31:0] cfg_rdata_q,
    input wire logic cfg_wr_ignored_q,
    input wire logic cfg_hit_q,
    input wire logic eeprom_load,
    input wire logic alias_wr,
    input wire logic [31:0] alias_word,
    input wire logic spl_valid,
    input wire logic [9:0] spl_payload,
    input wire logic [15:0] board_vendor_code_q,
    input wire logic [15:0] board_product_code_q,
    input wire logic [1:0] captured_power_scale_q,
    input wire logic [7:0] captured_power_value_q,
    input wire logic [17:0] slot_power_mw_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    function automatic logic [17:0] mw_of(input logic [1:0] s, input logic [7:0] v);
        case (s)
            2'h0: return v * MW_FACTOR_1_0;
            2'h1: return v * MW_FACTOR_0_1;
            2'h2: return v * MW_FACTOR_0_01;
            default: return v * MW_FACTOR_0_001;
        endcase
    endfunction
    sequence full_rd(logic [5:0] dw);
        cfg_req && !cfg_wr && cfg_addr[7:2] == dw && cfg_be == 4'hf;
    endsequence
    AST_ACK_NEXT: assert property (cfg_req |=> cfg_ack_q)
        else $error("request not acknowledged one cycle later");
    AST_ACK_CAUSE: assert property (cfg_ack_q |-> $past(cfg_req))
        else $error("acknowledge without a request");
    AST_WR_NOCHANGE: assert property (cfg_req && cfg_wr |=>
        cfg_rdata_q == 32'h0 && cfg_wr_ignored_q == cfg_hit_q)
        else $error("write answered wrongly");
    AST_RD_80: assert property (full_rd(6'h20) |=> cfg_rdata_q == 32'h0000_900d)
        else $error("board id item header dword wrong");
    AST_RD_90: assert property (full_rd(6'h24) |=> cfg_rdata_q == 32'h0071_0010)
        else $error("express item header dword wrong");
    AST_RD_94: assert property (full_rd(6'h25) |=> cfg_rdata_q == {4'h0,
        $past(captured_power_scale_q), $past(captured_power_value_q), 18'h08002})
        else $error("feature dword wrong");
    AST_CAPTURE: assert property (spl_valid |=>
        {captured_power_scale_q, captured_power_value_q} == $past(spl_payload))
        else $error("message payload not captured");
    AST_MW: assert property (spl_valid |-> ##2
        slot_power_mw_q == mw_of($past(spl_payload[9:8], 2), $past(spl_payload[7:0], 2)))
        else $error("power limit product wrong");
    AST_CODES_HOLD: assert property (!eeprom_load && !alias_wr |=>
        $stable(board_vendor_code_q) && $stable(board_product_code_q))
        else $error("board codes changed without a load");
    AST_ALIAS: assert property (alias_wr |=>
        {board_product_code_q, board_vendor_code_q} == $past(alias_word))
        else $error("alias load not taken");
    COV_MSG: cover property (spl_valid ##1 spl_valid);
    COV_ALIAS: cover property (alias_wr && eeprom_load);
    COV_WR: cover property (cfg_req && cfg_wr ##1 cfg_req && !cfg_wr);
endmodule // pccr_regs_sva

bind pccr_regs pccr_regs_sva u_sva (.mclk, .rst_b, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be,
    .cfg_ack_q, .cfg_rdata_q, .cfg_wr_ignored_q, .cfg_hit_q, .eeprom_load, .alias_wr,
    .alias_word, .spl_valid, .spl_payload, .board_vendor_code_q, .board_product_code_q,
    .captured_power_scale_q, .captured_power_value_q, .slot_power_mw_q);

/* pcie_capability_config_regs_tb_top.sv */
// self-checking testbench for the capability register bank
`timescale 1ns/10ps
module pcie_capability_config_regs_tb_top
    import pccr_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic warm_reset = 1'b0;
    logic cfg_req = 1'b0;
    logic cfg_wr = 1'b0;
    logic [7:0] cfg_addr = 8'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic eeprom_load = 1'b0;
    logic alias_wr = 1'b0;
    logic [31:0] eeprom_word = 32'h0;
    logic [31:0] alias_word = 32'h0;
    logic cfg_ack_q, cfg_hit_q, cfg_wr_ignored_q, spl_valid;
    logic [31:0] cfg_rdata_q;
    logic [9:0] spl_payload;
    logic [15:0] vend, prod;
    logic [1:0] scale;
    logic [7:0] value;
    logic [17:0] mw;
    int compares = 0;
    int miscompares = 0;
    int cycles = 0;
    pccr_host_model host (.mclk(mclk), .spl_valid(spl_valid), .spl_payload(spl_payload));
    pccr_regs uut (.mclk(mclk), .rst_b(rst_b), .warm_reset(warm_reset), .cfg_req(cfg_req),
        .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
        .cfg_ack_q(cfg_ack_q), .cfg_hit_q(cfg_hit_q), .cfg_rdata_q(cfg_rdata_q),
        .cfg_wr_ignored_q(cfg_wr_ignored_q), .eeprom_load(eeprom_load),
        .eeprom_word(eeprom_word), .alias_wr(alias_wr), .alias_word(alias_word),
        .spl_valid(spl_valid), .spl_payload(spl_payload), .board_vendor_code_q(vend),
        .board_product_code_q(prod), .captured_power_scale_q(scale),
        .captured_power_value_q(value), .slot_power_mw_q(mw));
    initial begin
        forever #5 mclk = ~mclk;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic complete_run;
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request stays up so calls run back to back; idle drops it
    task automatic cfg(input logic wr, input logic [7:0] a, input logic [3:0] be,
        input logic [31:0] exp, input logic hit);
        cfg_req = 1'b1;
        cfg_wr = wr;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = 32'hffff_ffff;
        @(negedge mclk);
        check({cfg_ack_q, cfg_hit_q, cfg_wr_ignored_q}, {1'b1, hit, wr & hit});
        check(cfg_rdata_q, exp);
    endtask
    task automatic idle;
        cfg_req = 1'b0;
        @(negedge mclk);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic fixed_reads;
        cfg(1'b0, OFS_SUBSYS_CAP_HEADER, 4'hf, 32'h0000_900d, 1'b1);
        cfg(1'b0, 8'h83, 4'h1, 32'h0000_000d, 1'b1);
        cfg(1'b0, OFS_SUBSYS_CAP_LINK, 4'h2, 32'h0000_9000, 1'b1);
        cfg(1'b0, OFS_EXPRESS_CAP_HEADER, 4'h3, 32'h0000_0010, 1'b1);
        cfg(1'b0, OFS_EXPRESS_CAP_LINK, 4'hf, 32'h0071_0010, 1'b1);
        cfg(1'b0, OFS_EXPRESS_CAP_SUMMARY, 4'hc, 32'h0071_0000, 1'b1);
        cfg(1'b0, OFS_DEVICE_FEATURE, 4'hf, 32'h0000_8002, 1'b1);
        cfg(1'b0, 8'h88, 4'hf, 32'h0, 1'b0);
        cfg(1'b0, OFS_BOARD_VENDOR, 4'hf, 32'h0, 1'b1);
        idle();
    endtask
    task automatic id_loads;
        eeprom_load = 1'b1;
        eeprom_word = 32'h5a5a_1234;
        @(negedge mclk);
        alias_wr = 1'b1;
        alias_word = 32'hbeef_cafe;
        eeprom_word = 32'h1111_2222;
        check({prod, vend}, 32'h5a5a_1234);
        @(negedge mclk);
        eeprom_load = 1'b0;
        alias_wr = 1'b0;
        warm_reset = 1'b1;
        check({prod, vend}, 32'hbeef_cafe);
        @(negedge mclk);
        warm_reset = 1'b0;
        cfg(1'b1, OFS_BOARD_VENDOR, 4'hf, 32'h0, 1'b1);
        cfg(1'b1, OFS_DEVICE_FEATURE, 4'hf, 32'h0, 1'b1);
        cfg(1'b0, OFS_BOARD_PRODUCT, 4'hf, 32'hbeef_cafe, 1'b1);
        idle();
        rst_b = 1'b0;
        @(negedge mclk);
        rst_b = 1'b1;
        check({prod, vend}, 32'h0);
    endtask
    task automatic power_limits;
        logic [17:0] fac;
        logic [7:0] v;
        for (int s = 0; s < 4; s++) begin
            fac = (s == 0) ? 18'h003e8 : (s == 1) ? 18'h00064 : (s == 2) ? 18'h0000a : 18'h1;
            v = 8'hff - 8'(s);
            host.send_limit(2'(s), v);
            check({scale, value}, {2'(s), v});
            @(negedge mclk);
            check(mw, v * fac);
            // a write between capture and read must not disturb the captured fields
            cfg(1'b1, OFS_DEVICE_FEATURE, 4'hf, 32'h0, 1'b1);
            cfg(1'b0, OFS_DEVICE_FEATURE, 4'hf, {4'h0, 2'(s), v, 18'h08002}, 1'b1);
            idle();
        end
        warm_reset = 1'b1;
        host.send_limit(2'h1, 8'h10);
        check({scale, value}, {2'h1, 8'h10});
        @(negedge mclk);
        warm_reset = 1'b0;
        check({scale, value}, 10'h0);
    endtask
    // ------------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------------
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, cycles, 0);
            complete_run();
        end
    end
    initial begin
        repeat (3) @(negedge mclk);
        rst_b = 1'b1;
        fixed_reads();
        id_loads();
        power_limits();
        complete_run();
    end
endmodule // pcie_capability_config_regs_tb_top
